// ===== design/cub_fifo.sv
`timescale 1ns/1ps
module cub_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input wire logic clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic in_valid, // Write side offers a word.
  input wire logic [W-1:0] in_data, // Word to store.
  output logic in_ready, // Room for one more word.
  output logic out_valid, // Output register holds a word.
  output logic [W-1:0] out_data, // Oldest word.
  input wire logic out_ready // Reader takes the word.
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ir;
    logic ov;
    logic [W-1:0] od;
  } cub_fifo_st_type;

  cub_fifo_st_type s_ff;
  cub_fifo_st_type nxt_s;
  logic [W-1:0] mem [D];
  logic push;

  // Depth must be a power of two so that the pointers wrap by themselves.
  always_comb begin
    nxt_s = s_ff;
    push = in_valid && s_ff.ir;
    if (s_ff.ov && out_ready) begin
      nxt_s.ov = 1'b0;
    end
    if (s_ff.cnt != '0 && (!s_ff.ov || out_ready)) begin
      nxt_s.od = mem[s_ff.rp];
      nxt_s.ov = 1'b1;
      nxt_s.rp = s_ff.rp + 1'b1;
      nxt_s.cnt = nxt_s.cnt - 1'b1;
    end
    if (push) begin
      nxt_s.wp = s_ff.wp + 1'b1;
      nxt_s.cnt = nxt_s.cnt + 1'b1;
    end
    nxt_s.ir = nxt_s.cnt < (AW+1)'(D);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_ff.wp] <= in_data;
    end
  end

  assign in_ready = s_ff.ir;
  assign out_valid = s_ff.ov;
  assign out_data = s_ff.od;
endmodule : cub_fifo

// ===== design/cub_pkg.sv
package cub_pkg;
  // Forward receive buffer: one FEC block plus its header words.
  localparam int RX_DEPTH = 5992;
  localparam int RX_W = 10;
  localparam int RX_AW = 13;
  // Return link: two pages of burst symbols.
  localparam int TX_PAGE = 5088;
  localparam int TX_W = 4;
  localparam int TX_AW = 13;
  localparam int TX_IW = 14;
  localparam int TX_PAGES = 2;
  // Read-data FIFO between the forward buffer and the channel unit.
  localparam int FIFO_DEPTH = 16;
  localparam logic [RX_AW-1:0] RX_DEPTH_C = 13'h1768;
  localparam logic [TX_AW-1:0] TX_PAGE_C = 13'h13e0;
  localparam logic [TX_AW-1:0] TX_LAST_C = 13'h13df;

  typedef enum logic [2:0] {
    FS_IDLE = 3'h1,
    FS_READ = 3'h2,
    FS_DONE = 3'h4
  } cub_fwd_state_type;
endpackage : cub_pkg

// ===== design/cub_top.sv
// What this block does
// - All shared block buffers are synchronous RAM built from clocked storage.
// - The unit's state machine picks bus direction and who drives the address.
// - The unit reads the forward buffer with strobe and 10-bit data.
// - Baseband raises block ready when a block is written; the unit clears it.
// - Forward buffer is single port; writer and reader take turns, never together.
// - Forward buffer holds 5992 words: one FEC block plus header.
// - A new block read may start once decoding is in its second half.
// - Reads are held back so no unwritten location is ever read.
// - Return buffer is single-port RAM, two pages whose roles toggle.
// - The unit writes return symbols with strobe and 4-bit data.
// - Each return page holds 5088 entries of 4 bits.
// - A page holds the complete burst before the baseband gets it.
// - Parameters, control and status are exposed for the host to reach.
`timescale 1ns/1ps
module cub_top (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic rx_symbol_write_clock, // Baseband symbol clock pin.
  input wire logic rx_symbol_write_valid, // Baseband write strobe pin.
  input wire logic [cub_pkg::RX_W-1:0] rx_symbol_write_bus, // Baseband write data pins.
  input wire logic rx_block_written, // Baseband pin: block complete, sets ready.
  output logic rx_block_ready_flag, // Forward block waiting in the buffer.
  input wire logic dec_second_half, // Decoder is in its second half.
  input wire logic dec_idle, // Decoder has no block in hand.
  input wire logic [cub_pkg::RX_AW-1:0] rx_block_len, // Words per block, 0 means full.
  output logic rx_block_read_valid, // Read data word available.
  output logic [cub_pkg::RX_W-1:0] rx_block_read_bus, // Read data word.
  input wire logic rx_block_read_ready, // Channel unit accepts the word.
  output logic rx_read_busy, // Forward read in progress.
  input wire logic tx_burst_write_valid, // Burst symbol offered.
  input wire logic [cub_pkg::TX_W-1:0] tx_burst_write_bus, // Burst symbol.
  input wire logic tx_burst_write_last, // Symbol ends the burst.
  output logic tx_burst_write_ready, // Writer may hand a symbol.
  input wire logic tx_burst_read_clock, // Baseband read clock pin.
  output logic tx_burst_read_valid, // Burst symbol on the bus.
  output logic [cub_pkg::TX_W-1:0] tx_burst_read_bus, // Burst symbol for the baseband.
  output logic tx_page_pending // A full page waits for the baseband.
);
  typedef struct packed {
    logic wck_s1;
    logic wck_s2;
    logic wck_q;
    logic wv_s1;
    logic wv_s2;
    logic [cub_pkg::RX_W-1:0] wd_s1;
    logic [cub_pkg::RX_W-1:0] wd_s2;
    logic dn_s1;
    logic dn_s2;
    logic dn_q;
    logic rck_s1;
    logic rck_s2;
    logic rck_q;
    logic flag;
    logic wpend;
    logic [cub_pkg::RX_W-1:0] wdata;
    logic [cub_pkg::RX_AW-1:0] wcnt;
    cub_pkg::cub_fwd_state_type fst;
    logic [cub_pkg::RX_AW-1:0] blen;
    logic [cub_pkg::RX_AW-1:0] raddr;
    logic rinfl;
    logic busy;
    logic wpg;
    logic [cub_pkg::TX_PAGES-1:0] full;
    logic [cub_pkg::TX_PAGES-1:0][cub_pkg::TX_AW-1:0] tlen;
    logic [cub_pkg::TX_AW-1:0] twaddr;
    logic [cub_pkg::TX_AW-1:0] traddr;
    logic rpend;
    logic wrdy;
    logic tvalid;
    logic pend;
  } cub_top_st_type;

  localparam cub_top_st_type ST_RST = '{fst: cub_pkg::FS_IDLE, default: '0};

  cub_top_st_type s_ff;
  cub_top_st_type nxt_s;
  logic [cub_pkg::RX_W-1:0] rx_mem [cub_pkg::RX_DEPTH];
  logic [cub_pkg::TX_W-1:0] tx_mem [cub_pkg::TX_PAGES*cub_pkg::TX_PAGE];
  logic [cub_pkg::RX_W-1:0] rx_q_ff;
  logic [cub_pkg::TX_W-1:0] tx_q_ff;
  logic rx_we;
  logic rx_re;
  logic tx_we;
  logic tx_re;
  logic rpg;
  logic [cub_pkg::TX_IW-1:0] tx_widx;
  logic [cub_pkg::TX_IW-1:0] tx_ridx;
  logic fifo_in_ready;

  always_comb begin
    nxt_s = s_ff;
    // Pins cross into clk through two flops; stage one is never looked at, edges compare stage two with a third flop.
    nxt_s.wck_s1 = rx_symbol_write_clock;
    nxt_s.wck_s2 = s_ff.wck_s1;
    nxt_s.wck_q = s_ff.wck_s2;
    nxt_s.wv_s1 = rx_symbol_write_valid;
    nxt_s.wv_s2 = s_ff.wv_s1;
    nxt_s.wd_s1 = rx_symbol_write_bus;
    nxt_s.wd_s2 = s_ff.wd_s1;
    nxt_s.dn_s1 = rx_block_written;
    nxt_s.dn_s2 = s_ff.dn_s1;
    nxt_s.dn_q = s_ff.dn_s2;
    nxt_s.rck_s1 = tx_burst_read_clock;
    nxt_s.rck_s2 = s_ff.rck_s1;
    nxt_s.rck_q = s_ff.rck_s2;

    // Forward port owner: a pending baseband write always wins the single port,
    // the reader only gets the cycles left over.
    rx_we = s_ff.wpend;
    rx_re = (s_ff.fst == cub_pkg::FS_READ) && !s_ff.wpend && !s_ff.rinfl &&
            fifo_in_ready && (s_ff.raddr < s_ff.blen) &&
            (s_ff.raddr < s_ff.wcnt);

    // Baseband write: each word lands at the next address until 5992 are held; later words are dropped.
    if (rx_we) begin
      nxt_s.wpend = 1'b0;
      if (s_ff.wcnt < cub_pkg::RX_DEPTH_C) begin
        nxt_s.wcnt = s_ff.wcnt + 1'b1;
      end
    end
    if (s_ff.wck_s2 && !s_ff.wck_q && s_ff.wv_s2) begin
      nxt_s.wpend = 1'b1;
      nxt_s.wdata = s_ff.wd_s2;
    end

    nxt_s.rinfl = rx_re;
    if (rx_re) begin
      nxt_s.raddr = s_ff.raddr + 1'b1;
    end

    case (s_ff.fst)
      cub_pkg::FS_IDLE: begin
        if (s_ff.flag && (dec_second_half || dec_idle)) begin
          nxt_s.fst = cub_pkg::FS_READ;
          nxt_s.raddr = '0;
          if (rx_block_len == '0 || rx_block_len > cub_pkg::RX_DEPTH_C) begin
            nxt_s.blen = cub_pkg::RX_DEPTH_C;
          end else begin
            nxt_s.blen = rx_block_len;
          end
        end
      end
      cub_pkg::FS_READ: begin
        if (s_ff.raddr == s_ff.blen && !s_ff.rinfl) begin
          nxt_s.fst = cub_pkg::FS_DONE;
        end
      end
      cub_pkg::FS_DONE: begin
        // Whole block consumed: release it and rewind the writer.
        nxt_s.flag = 1'b0;
        nxt_s.wcnt = '0;
        nxt_s.fst = cub_pkg::FS_IDLE;
      end
      default: begin
        nxt_s.fst = cub_pkg::FS_IDLE;
      end
    endcase
    // A ready edge in the clearing cycle still counts.
    if (s_ff.dn_s2 && !s_ff.dn_q) begin
      nxt_s.flag = 1'b1;
    end
    nxt_s.busy = nxt_s.fst != cub_pkg::FS_IDLE;

    // Return link: writer owns page wpg, the baseband reads the other one.
    rpg = ~s_ff.wpg;
    tx_we = tx_burst_write_valid && s_ff.wrdy;
    tx_re = s_ff.rpend;
    tx_widx = s_ff.wpg ? cub_pkg::TX_IW'(cub_pkg::TX_PAGE) + {1'b0, s_ff.twaddr}
                       : {1'b0, s_ff.twaddr};
    tx_ridx = rpg ? cub_pkg::TX_IW'(cub_pkg::TX_PAGE) + {1'b0, s_ff.traddr}
                  : {1'b0, s_ff.traddr};

    if (tx_we) begin
      nxt_s.twaddr = s_ff.twaddr + 1'b1;
      if (tx_burst_write_last || s_ff.twaddr == cub_pkg::TX_LAST_C) begin
        nxt_s.full[s_ff.wpg] = 1'b1;
        nxt_s.tlen[s_ff.wpg] = s_ff.twaddr + 1'b1;
        nxt_s.twaddr = '0;
      end
    end

    if (tx_re) begin
      nxt_s.rpend = 1'b0;
      nxt_s.tvalid = 1'b1;
      nxt_s.traddr = s_ff.traddr + 1'b1;
      if (s_ff.traddr + 1'b1 == s_ff.tlen[rpg]) begin
        nxt_s.full[rpg] = 1'b0;
        nxt_s.traddr = '0;
      end
    end
    if (s_ff.rck_s2 && !s_ff.rck_q) begin
      if (s_ff.full[rpg] && !s_ff.rpend) begin
        nxt_s.rpend = 1'b1;
      end else begin
        nxt_s.tvalid = 1'b0;
      end
    end

    // Swap only when the writer's burst is complete and the reader is done.
    if (nxt_s.full[nxt_s.wpg] && !nxt_s.full[~nxt_s.wpg] && !nxt_s.rpend) begin
      nxt_s.wpg = ~nxt_s.wpg;
    end
    // The reader's fetch takes the port, so the writer is stalled that cycle.
    nxt_s.wrdy = !nxt_s.full[nxt_s.wpg] && !nxt_s.rpend;
    nxt_s.pend = nxt_s.full[~nxt_s.wpg];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Storage has no reset; a page or block is only read after it was written.
  always_ff @(posedge clk) begin
    if (rx_we && s_ff.wcnt < cub_pkg::RX_DEPTH_C) begin
      rx_mem[s_ff.wcnt] <= s_ff.wdata;
    end else if (rx_re) begin
      rx_q_ff <= rx_mem[s_ff.raddr];
    end
  end

  always_ff @(posedge clk) begin
    if (tx_we) begin
      tx_mem[tx_widx] <= tx_burst_write_bus;
    end else if (tx_re) begin
      tx_q_ff <= tx_mem[tx_ridx];
    end
  end

  // Read data stages through the FIFO so the consumer may stall the reader.
  cub_fifo #(
    .W(cub_pkg::RX_W),
    .D(cub_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(s_ff.rinfl),
    .in_data(rx_q_ff),
    .in_ready(fifo_in_ready),
    .out_valid(rx_block_read_valid),
    .out_data(rx_block_read_bus),
    .out_ready(rx_block_read_ready)
  );

  assign rx_block_ready_flag = s_ff.flag;
  assign rx_read_busy = s_ff.busy;
  assign tx_burst_write_ready = s_ff.wrdy;
  assign tx_burst_read_valid = s_ff.tvalid;
  assign tx_burst_read_bus = tx_q_ff;
  assign tx_page_pending = s_ff.pend;
endmodule : cub_top

// ===== dv/cub_bb_model.sv
`timescale 1ns/1ps
module cub_bb_model (
  output logic rx_symbol_write_clock, // Symbol clock, still between blocks.
  output logic rx_symbol_write_valid, // Write strobe.
  output logic [cub_pkg::RX_W-1:0] rx_symbol_write_bus, // Write word.
  output logic rx_block_written, // Block complete.
  output logic tx_burst_read_clock, // Fetch clock, still between bursts.
  input wire logic [cub_pkg::TX_W-1:0] tx_burst_read_bus // Fetched symbol.
);
  logic [cub_pkg::TX_W-1:0] got [$];
  initial begin
    rx_symbol_write_clock = 1'b0;
    rx_symbol_write_valid = 1'b0;
    rx_symbol_write_bus = 10'h0;
    rx_block_written = 1'b0;
    tx_burst_read_clock = 1'b0;
  end
  // Word i of the block carries base plus i, so each word can be told apart.
  task automatic write_block(input int n, input logic [9:0] base);
    for (int i = 0; i < n; i++) begin
      rx_symbol_write_bus = base + 10'(i);
      rx_symbol_write_valid = 1'b1;
      #200 rx_symbol_write_clock = 1'b1;
      #400 rx_symbol_write_clock = 1'b0;
      #200;
    end
    rx_symbol_write_valid = 1'b0;
    // Inverted after release so that a stale word can never pass for a fresh one.
    rx_symbol_write_bus = ~rx_symbol_write_bus;
    rx_block_written = 1'b1;
    #1000 rx_block_written = 1'b0;
  endtask : write_block
  task automatic fetch(input int n);
    for (int i = 0; i < n; i++) begin
      tx_burst_read_clock = 1'b1;
      #400 tx_burst_read_clock = 1'b0;
      #390 got.push_back(tx_burst_read_bus);
      #10;
    end
  endtask : fetch
endmodule : cub_bb_model

// ===== dv/cub_top_monitor.sv
`timescale 1ns/1ps
module cub_top_monitor (
  input wire logic clk, // System clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic rx_block_written, // Block done pin.
  input wire logic rx_block_ready_flag, // Block waiting.
  input wire logic dec_second_half, // Decoder in second half.
  input wire logic dec_idle, // Decoder idle.
  input wire logic rx_block_read_valid, // Read word valid.
  input wire logic [cub_pkg::RX_W-1:0] rx_block_read_bus, // Read word.
  input wire logic rx_block_read_ready, // Read accept.
  input wire logic rx_read_busy, // Read in progress.
  input wire logic tx_burst_write_valid, // Symbol offered.
  input wire logic tx_burst_write_last, // Burst end.
  input wire logic tx_burst_write_ready, // Symbol accepted.
  input wire logic tx_burst_read_clock, // Fetch clock pin.
  input wire logic tx_burst_read_valid, // Fetched symbol valid.
  input wire logic [cub_pkg::TX_W-1:0] tx_burst_read_bus, // Fetched symbol.
  input wire logic tx_page_pending // Full page waits.
);
  logic [3:0] rc_cnt_ff;
  logic rc_prev_ff;
  logic [12:0] pg_cnt_ff;
  logic take;
  assign take = tx_burst_write_valid && tx_burst_write_ready;
  // Idle time of the fetch clock saturates, so a held symbol can be judged after sync delay.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rc_cnt_ff <= 4'h0;
      rc_prev_ff <= 1'b0;
      pg_cnt_ff <= 13'h0;
    end else begin
      rc_prev_ff <= tx_burst_read_clock;
      if (tx_burst_read_clock != rc_prev_ff) rc_cnt_ff <= 4'h0;
      else if (rc_cnt_ff != 4'hf) rc_cnt_ff <= rc_cnt_ff + 4'h1;
      if (take && (tx_burst_write_last || pg_cnt_ff == cub_pkg::TX_LAST_C)) pg_cnt_ff <= 13'h0;
      else if (take) pg_cnt_ff <= pg_cnt_ff + 13'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_start_ready: assert property ($rose(rx_read_busy) |-> rx_block_ready_flag)
    else $error("read started without ready flag");
  chk_start_dec: assert property ($rose(rx_read_busy) |-> $past(dec_second_half) || $past(dec_idle))
    else $error("read started while decoder busy in first half");
  chk_flag_clear: assert property ($fell(rx_block_ready_flag) |-> !rx_read_busy)
    else $error("ready flag cleared during read");
  chk_flag_cause: assert property ($rose(rx_block_ready_flag) |-> $past(rx_block_written, 3))
    else $error("ready flag set without block done");
  chk_read_hold: assert property (rx_block_read_valid && !rx_block_read_ready
    |=> rx_block_read_valid && $stable(rx_block_read_bus))
    else $error("read word dropped while stalled");
  chk_page_close: assert property (take && (tx_burst_write_last || pg_cnt_ff == cub_pkg::TX_LAST_C)
    |-> ##[1:2] (tx_page_pending || !tx_burst_write_ready))
    else $error("burst page not closed");
  chk_fetch_page: assert property ($rose(tx_burst_read_valid) |-> $past(tx_page_pending))
    else $error("symbol fetched without full page");
  chk_sym_hold: assert property (rc_cnt_ff >= 4'h8 && tx_burst_read_valid
    |=> tx_burst_read_valid && $stable(tx_burst_read_bus))
    else $error("symbol changed without fetch clock");
endmodule : cub_top_monitor

bind cub_top cub_top_monitor cub_top_monitor_i (.clk, .arst_n, .rx_block_written,
  .rx_block_ready_flag, .dec_second_half, .dec_idle, .rx_block_read_valid, .rx_block_read_bus,
  .rx_block_read_ready, .rx_read_busy, .tx_burst_write_valid, .tx_burst_write_last,
  .tx_burst_write_ready, .tx_burst_read_clock, .tx_burst_read_valid, .tx_burst_read_bus,
  .tx_page_pending);

// ===== dv/tb_cub_top.sv
`timescale 1ns/1ps
module tb_cub_top;
  logic clk = 1'b0;
  logic arst_n, rx_symbol_write_clock, rx_symbol_write_valid, rx_block_written;
  logic [9:0] rx_symbol_write_bus, rx_block_read_bus;
  logic rx_block_ready_flag, dec_second_half, dec_idle, rx_block_read_valid;
  logic [12:0] rx_block_len;
  logic rx_block_read_ready, rx_read_busy, tx_burst_write_valid, tx_burst_write_last;
  logic [3:0] tx_burst_write_bus, tx_burst_read_bus;
  logic tx_burst_write_ready, tx_burst_read_clock, tx_burst_read_valid, tx_page_pending;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  cub_top cub_top_i (.clk, .arst_n, .rx_symbol_write_clock, .rx_symbol_write_valid,
    .rx_symbol_write_bus, .rx_block_written, .rx_block_ready_flag, .dec_second_half, .dec_idle,
    .rx_block_len, .rx_block_read_valid, .rx_block_read_bus, .rx_block_read_ready, .rx_read_busy,
    .tx_burst_write_valid, .tx_burst_write_bus, .tx_burst_write_last, .tx_burst_write_ready,
    .tx_burst_read_clock, .tx_burst_read_valid, .tx_burst_read_bus, .tx_page_pending);
  cub_bb_model cub_bb_model_i (.rx_symbol_write_clock, .rx_symbol_write_valid,
    .rx_symbol_write_bus, .rx_block_written, .tx_burst_read_clock, .tx_burst_read_bus);
  task stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task t_reset;
    repeat (2) @(posedge clk);
    chk_val("write ready in reset", 16'h0, tx_burst_write_ready);
    @(negedge clk) arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_val("write ready", 16'h1, tx_burst_write_ready);
  endtask : t_reset
  task t_rx(input int nw, input logic [12:0] len, input logic [9:0] base, input logic idle);
    int got;
    dec_idle = idle;
    rx_block_len = len;
    cub_bb_model_i.write_block(nw, base);
    // An idle decoder drains a short block quickly, so the flag is judged at once.
    chk_val("ready flag", 16'h1, rx_block_ready_flag);
    repeat (6) @(negedge clk);
    if (!idle) chk_val("early start", 16'h0, rx_read_busy);
    if (!idle) chk_val("flag held", 16'h1, rx_block_ready_flag);
    dec_second_half = 1'b1;
    got = 0;
    // Stalling every third cycle keeps the output word waiting on the consumer.
    for (int c = 0; c < 400 && got < len; c++) begin
      @(negedge clk);
      rx_block_read_ready = (c % 3 != 0);
      if (rx_block_read_ready && rx_block_read_valid === 1'b1) begin
        chk_val("read word", base + 10'(got), rx_block_read_bus);
        got++;
      end
    end
    @(negedge clk) rx_block_read_ready = 1'b0;
    repeat (6) @(negedge clk);
    chk_val("words read", 16'(len), 16'(got));
    chk_val("flag cleared", 16'h0, rx_block_ready_flag);
    chk_val("busy", 16'h0, rx_read_busy);
    chk_val("extra word", 16'h0, rx_block_read_valid);
    dec_second_half = 1'b0;
    dec_idle = 1'b0;
  endtask : t_rx
  task tx_send(input logic [3:0] s, input logic l);
    @(negedge clk);
    tx_burst_write_valid = 1'b1;
    tx_burst_write_bus = s;
    tx_burst_write_last = l;
    while (tx_burst_write_ready !== 1'b1) @(negedge clk);
  endtask : tx_send
  task t_tx_bursts;
    logic [3:0] e [5] = '{4'h5, 4'ha, 4'h3, 4'hc, 4'h6};
    for (int i = 0; i < 5; i++) tx_send(e[i], i == 2 || i == 4);
    @(negedge clk) tx_burst_write_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk_val("page pending", 16'h1, tx_page_pending);
    cub_bb_model_i.fetch(5);
    for (int i = 0; i < 5; i++) chk_val("burst symbol", e[i], cub_bb_model_i.got[i]);
    @(negedge clk);
    chk_val("pages drained", 16'h0, tx_page_pending);
  endtask : t_tx_bursts
  task t_tx_full;
    for (int i = 0; i < 5087; i++) tx_send(4'(i), 1'b0);
    @(negedge clk) tx_burst_write_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk_val("page open", 16'h0, tx_page_pending);
    tx_send(4'h7, 1'b0);
    @(negedge clk) tx_burst_write_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk_val("page full", 16'h1, tx_page_pending);
  endtask : t_tx_full
  initial begin
    arst_n = 1'b0;
    dec_second_half = 1'b0;
    dec_idle = 1'b0;
    rx_block_len = 13'h0;
    rx_block_read_ready = 1'b0;
    tx_burst_write_valid = 1'b0;
    tx_burst_write_bus = 4'h0;
    tx_burst_write_last = 1'b0;
    t_reset();
    t_rx(5, 13'h5, 10'h3a0, 1'b0);
    t_rx(4, 13'h3, 10'h11f, 1'b1);
    t_tx_bursts();
    t_tx_full();
    stop_test();
  end
endmodule : tb_cub_top
